// ### intc_pkg.sv
// Constants, register map and field layout of the controller.
// Assumes a 32-bit Avalon-MM register bus with byte addresses and one clock.
package intc_pkg;

    localparam int NUM_SRC = 8;
    localparam int NUM_CH  = 8;
    localparam int NUM_EXT = 2;
    localparam int SRC_W   = 3;
    localparam int PRIO_W  = 4;

    // Trap number of source 0; source i uses the next numbers in order.
    localparam logic [7:0] TRAP_BASE = 8'h10;

    // Source control register fields.
    localparam int PRIO_LSB = 0;
    localparam int EN_BIT   = 4;
    localparam int REQ_BIT  = 5;
    localparam int XFER_BIT = 6;
    localparam int CH_LSB   = 8;
    localparam int EDGE_LSB = 12;
    localparam logic [15:0] CTRL_MASK = 16'h3_77F;

    // External edge selection codes.
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Channel control register fields.
    localparam int BYTE_BIT   = 0;
    localparam int INCSRC_BIT = 1;
    localparam int INCDST_BIT = 2;
    localparam int CONT_BIT   = 3;

    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [7:0]  CNT_ONE   = 8'h01;

    // Register banks, selected by address bits 7:5; bits 4:2 pick the entry.
    localparam logic [2:0] BANK_CTRL = 3'h0;
    localparam logic [2:0] BANK_SRC  = 3'h1;
    localparam logic [2:0] BANK_DST  = 3'h2;
    localparam logic [2:0] BANK_CNT  = 3'h3;
    localparam logic [2:0] BANK_CTL  = 3'h4;
    localparam logic [2:0] BANK_MISC = 3'h5;
    localparam logic [2:0] MISC_STATUS = 3'h0;
    localparam logic [2:0] MISC_MASK   = 3'h1;
    localparam logic [2:0] MISC_CORE   = 3'h2;

    function automatic logic [15:0] vector_of(input logic [7:0] trap);
        vector_of = {6'h00, trap, 2'h0};
    endfunction : vector_of

endpackage : intc_pkg

// ### pin_edge_detect.sv
// Synchronises the fast external request pins and detects the selected edges.
// Assumes asynchronous pins and a same-clock mode.
`timescale 1ns/10ps
module pin_edge_detect
(
    input  wire logic                           sys_clk,
    input  wire logic                           sys_rst,
    input  wire logic [intc_pkg::NUM_EXT-1:0]   pin,
    input  wire logic [2*intc_pkg::NUM_EXT-1:0] mode,
    output logic      [intc_pkg::NUM_EXT-1:0]   edge_pulse
);

    typedef struct packed {
        logic [intc_pkg::NUM_EXT-1:0] sync1;
        logic [intc_pkg::NUM_EXT-1:0] sync2;
        logic [intc_pkg::NUM_EXT-1:0] prev;
        logic [intc_pkg::NUM_EXT-1:0] pulse;
    } edge_s;

    edge_s r;
    edge_s next_r;

    always_comb
    begin
        next_r.sync1 = pin;
        next_r.sync2 = r.sync1;
        next_r.prev  = r.sync2;
        for (int i = 0; i < intc_pkg::NUM_EXT; i++)
        begin
            next_r.pulse[i] =
                ((mode[2*i +: 2] == intc_pkg::EDGE_RISE) && r.sync2[i] && !r.prev[i]) ||
                ((mode[2*i +: 2] == intc_pkg::EDGE_FALL) && !r.sync2[i] && r.prev[i]) ||
                ((mode[2*i +: 2] == intc_pkg::EDGE_BOTH) && (r.sync2[i] != r.prev[i]));
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            r <= '0;
        else
            r <= next_r;
    end

    assign edge_pulse = r.pulse;

endmodule : pin_edge_detect

// ### priority_select.sv
// Picks the pending enabled source with the highest level; ties go to the lower index.
// Combinational; the caller registers what it presents.
`timescale 1ns/10ps
module priority_select
(
    input  wire logic [intc_pkg::NUM_SRC-1:0]                  pending,
    input  wire logic [intc_pkg::NUM_SRC*intc_pkg::PRIO_W-1:0] levels,
    output logic                                               win_valid,
    output logic      [intc_pkg::SRC_W-1:0]                    win_index,
    output logic      [intc_pkg::PRIO_W-1:0]                   win_level
);

    always_comb
    begin
        win_valid = 1'b0;
        win_index = '0;
        win_level = '0;
        for (int i = 0; i < intc_pkg::NUM_SRC; i++)
        begin
            if (pending[i] &&
                (!win_valid || (levels[i*intc_pkg::PRIO_W +: intc_pkg::PRIO_W] > win_level)))
            begin
                win_valid = 1'b1;
                win_index = intc_pkg::SRC_W'(i);
                win_level = levels[i*intc_pkg::PRIO_W +: intc_pkg::PRIO_W];
            end
        end
    end

endmodule : priority_select

// ### interrupt_and_event_transfer_ctrl.sv
// Prioritised vectored interrupt controller with an eight-channel event transfer engine.
// Assumes a core that acknowledges vectors, performs the single-cycle moves it is given,
// and reports its current priority level; registers sit on Avalon-MM.
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps

// Contract
// - Internal request reaches the core within 5 to 12 clocks; here an idle controller raises int_req one clock after it samples the event.
// - Each source is set for vectored interrupt or event transfer.
// - A transfer steals one core cycle, no vector branch or suspension.
// - Moves one byte or word, then bumps source or destination pointer.
// - Count decrements per transfer unless the channel runs continuous.
// - At zero count the source raises its normal vectored interrupt instead.
// - Eight channels, each with source, destination, count and control.
// - Every source has a control register: request, enable, priority.
// - Priority field selects one of sixteen levels.
// - Only strictly higher priority preempts an accepted service.
// - Each source vectors to four times its trap number.
// - Fast external inputs detect rising, falling or both edges.
// - A trap instruction number vectors to its own location.
// - Software setting a request flag acts like a hardware event.
module interrupt_and_event_transfer_ctrl
(
    input  wire logic                          sys_clk,
    input  wire logic                          sys_rst,
    input  wire logic [7:0]                    address,
    input  wire logic                          read,
    input  wire logic                          write,
    input  wire logic [31:0]                   writedata,
    input  wire logic [3:0]                    byteenable,
    output logic      [31:0]                   readdata,
    output logic                               waitrequest,
    input  wire logic [intc_pkg::NUM_SRC-1:0]  src_event,
    input  wire logic [intc_pkg::NUM_EXT-1:0]  ext_pin,
    input  wire logic [intc_pkg::PRIO_W-1:0]   cpu_level,
    input  wire logic                          int_ack,
    input  wire logic                          xfer_done,
    input  wire logic                          trap_valid,
    input  wire logic [7:0]                    trap_num,
    output logic                               int_req,
    output logic      [15:0]                   int_vector,
    output logic      [intc_pkg::PRIO_W-1:0]   int_level,
    output logic                               xfer_req,
    output logic      [15:0]                   xfer_src,
    output logic      [15:0]                   xfer_dst,
    output logic                               xfer_word,
    output logic                               trap_ack,
    output logic                               irq
);

    typedef enum logic [1:0] {S_IDLE, S_INT, S_XFER} svc_e;

    typedef struct packed {
        logic [intc_pkg::NUM_SRC-1:0][15:0] ctrl;
        logic [intc_pkg::NUM_CH-1:0][15:0]  ch_src;
        logic [intc_pkg::NUM_CH-1:0][15:0]  ch_dst;
        logic [intc_pkg::NUM_CH-1:0][7:0]   ch_cnt;
        logic [intc_pkg::NUM_CH-1:0][3:0]   ch_ctl;
        logic [intc_pkg::NUM_CH-1:0]        status;
        logic [intc_pkg::NUM_CH-1:0]        mask;
        svc_e                               st;
        logic [intc_pkg::SRC_W-1:0]         sel;
        logic [2:0]                         ch;
        logic                               from_src;
        logic                               int_req;
        logic [15:0]                        int_vector;
        logic [intc_pkg::PRIO_W-1:0]        int_level;
        logic                               xfer_req;
        logic [15:0]                        xfer_src;
        logic [15:0]                        xfer_dst;
        logic                               xfer_word;
        logic                               trap_ack;
        logic                               irq;
        logic                               waitrequest;
        logic [31:0]                        readdata;
    } state_s;

    state_s r;
    state_s next_r;

    logic [intc_pkg::NUM_EXT-1:0]                  ext_edge;
    logic [2*intc_pkg::NUM_EXT-1:0]                edge_mode;
    logic [intc_pkg::NUM_SRC-1:0]                  pending;
    logic [intc_pkg::NUM_SRC*intc_pkg::PRIO_W-1:0] levels;
    logic                                          win_valid;
    logic [intc_pkg::SRC_W-1:0]                    win_index;
    logic [intc_pkg::PRIO_W-1:0]                   win_level;

    // Readback value of a register; also the base for byte-lane merges on writes.
    function automatic logic [31:0] reg_value(input state_s s, input logic [7:0] a);
        logic [2:0] idx;
        idx       = a[4:2];
        reg_value = '0;
        unique case (a[7:5])
            intc_pkg::BANK_CTRL: reg_value = {16'h0000, s.ctrl[idx]};
            intc_pkg::BANK_SRC:  reg_value = {16'h0000, s.ch_src[idx]};
            intc_pkg::BANK_DST:  reg_value = {16'h0000, s.ch_dst[idx]};
            intc_pkg::BANK_CNT:  reg_value = {24'h00_0000, s.ch_cnt[idx]};
            intc_pkg::BANK_CTL:  reg_value = {28'h000_0000, s.ch_ctl[idx]};
            intc_pkg::BANK_MISC:
            begin
                if (idx == intc_pkg::MISC_STATUS)
                    reg_value = {24'h00_0000, s.status};
                else if (idx == intc_pkg::MISC_MASK)
                    reg_value = {24'h00_0000, s.mask};
                else if (idx == intc_pkg::MISC_CORE)
                    reg_value = {24'h00_0000, s.st, s.ch, s.sel};
            end
            default: reg_value = '0;
        endcase
    endfunction : reg_value

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be);
        for (int b = 0; b < 4; b++)
            merge[8*b +: 8] = be[b] ? new_v[8*b +: 8] : old_v[8*b +: 8];
    endfunction : merge

    pin_edge_detect u_edge
    (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .pin        (ext_pin),
        .mode       (edge_mode),
        .edge_pulse (ext_edge)
    );

    always_comb
    begin
        for (int i = 0; i < intc_pkg::NUM_EXT; i++)
            edge_mode[2*i +: 2] = r.ctrl[i][intc_pkg::EDGE_LSB +: 2];
        for (int i = 0; i < intc_pkg::NUM_SRC; i++)
        begin
            pending[i] = r.ctrl[i][intc_pkg::REQ_BIT] && r.ctrl[i][intc_pkg::EN_BIT];
            levels[i*intc_pkg::PRIO_W +: intc_pkg::PRIO_W] =
                r.ctrl[i][intc_pkg::PRIO_LSB +: intc_pkg::PRIO_W];
        end
    end

    priority_select u_prio
    (
        .pending   (pending),
        .levels    (levels),
        .win_valid (win_valid),
        .win_index (win_index),
        .win_level (win_level)
    );

    always_comb
    begin
        logic [31:0] wv;
        logic [2:0]  idx;
        logic [2:0]  wch;
        logic [15:0] step;
        logic [7:0]  cnt_next;
        wv       = '0;
        idx      = address[4:2];
        wch      = '0;
        step     = '0;
        cnt_next = '0;
        next_r   = r;
        next_r.trap_ack = 1'b0;

        // Service sequencing towards the core.
        unique case (r.st)
            S_IDLE:
            begin
                if (trap_valid)
                begin
                    // Traps come from the instruction stream and bypass level checks.
                    next_r.int_req    = 1'b1;
                    next_r.int_vector = intc_pkg::vector_of(trap_num);
                    next_r.int_level  = cpu_level;
                    next_r.trap_ack   = 1'b1;
                    next_r.from_src   = 1'b0;
                    next_r.st         = S_INT;
                end
                else if (win_valid && (win_level > cpu_level))
                begin
                    wch        = r.ctrl[win_index][intc_pkg::CH_LSB +: 3];
                    next_r.sel = win_index;
                    next_r.ch  = wch;
                    if (r.ctrl[win_index][intc_pkg::XFER_BIT] && (r.ch_cnt[wch] != '0))
                    begin
                        next_r.xfer_req  = 1'b1;
                        next_r.xfer_src  = r.ch_src[wch];
                        next_r.xfer_dst  = r.ch_dst[wch];
                        next_r.xfer_word = !r.ch_ctl[wch][intc_pkg::BYTE_BIT];
                        next_r.ctrl[win_index][intc_pkg::REQ_BIT] = 1'b0;
                        next_r.st        = S_XFER;
                    end
                    else
                    begin
                        next_r.int_req    = 1'b1;
                        next_r.int_vector =
                            intc_pkg::vector_of(8'(intc_pkg::TRAP_BASE + 8'(win_index)));
                        next_r.int_level  = win_level;
                        next_r.from_src   = 1'b1;
                        next_r.st         = S_INT;
                    end
                end
            end
            S_INT:
            begin
                if (int_ack)
                begin
                    next_r.int_req = 1'b0;
                    if (r.from_src)
                        next_r.ctrl[r.sel][intc_pkg::REQ_BIT] = 1'b0;
                    next_r.st = S_IDLE;
                end
            end
            S_XFER:
            begin
                if (xfer_done)
                begin
                    next_r.xfer_req = 1'b0;
                    step = r.ch_ctl[r.ch][intc_pkg::BYTE_BIT] ? intc_pkg::STEP_BYTE
                                                              : intc_pkg::STEP_WORD;
                    if (r.ch_ctl[r.ch][intc_pkg::INCSRC_BIT])
                        next_r.ch_src[r.ch] = r.ch_src[r.ch] + step;
                    else if (r.ch_ctl[r.ch][intc_pkg::INCDST_BIT])
                        next_r.ch_dst[r.ch] = r.ch_dst[r.ch] + step;
                    if (!r.ch_ctl[r.ch][intc_pkg::CONT_BIT])
                    begin
                        cnt_next = r.ch_cnt[r.ch] - intc_pkg::CNT_ONE;
                        next_r.ch_cnt[r.ch] = cnt_next;
                        if (cnt_next == '0)
                        begin
                            // Re-arm the source so it vectors next time.
                            next_r.ctrl[r.sel][intc_pkg::REQ_BIT] = 1'b1;
                        end
                    end
                    next_r.st = S_IDLE;
                end
            end
        endcase

        // Register bus: one wait cycle, then the access completes.
        if ((read || write) && r.waitrequest)
        begin
            next_r.waitrequest = 1'b0;
            next_r.readdata    = reg_value(r, address);
        end
        else
        begin
            next_r.waitrequest = 1'b1;
        end

        if (write && !r.waitrequest)
        begin
            wv = merge(reg_value(r, address), writedata, byteenable);
            unique case (address[7:5])
                intc_pkg::BANK_CTRL:
                    next_r.ctrl[idx] = wv[15:0] & intc_pkg::CTRL_MASK;
                intc_pkg::BANK_SRC: next_r.ch_src[idx] = wv[15:0];
                intc_pkg::BANK_DST: next_r.ch_dst[idx] = wv[15:0];
                intc_pkg::BANK_CNT: next_r.ch_cnt[idx] = wv[7:0];
                intc_pkg::BANK_CTL: next_r.ch_ctl[idx] = wv[3:0];
                intc_pkg::BANK_MISC:
                begin
                    if (idx == intc_pkg::MISC_STATUS)
                        next_r.status = next_r.status & ~writedata[7:0];
                    else if (idx == intc_pkg::MISC_MASK)
                        next_r.mask = wv[7:0];
                end
                default: ;
            endcase
        end

        // Hardware events come last so that a simultaneous clear never loses them.
        for (int i = 0; i < intc_pkg::NUM_SRC; i++)
        begin
            if (src_event[i] || ((i < intc_pkg::NUM_EXT) && ext_edge[i % intc_pkg::NUM_EXT]))
                next_r.ctrl[i][intc_pkg::REQ_BIT] = 1'b1;
        end
        if ((r.st == S_XFER) && xfer_done && !r.ch_ctl[r.ch][intc_pkg::CONT_BIT] &&
            (r.ch_cnt[r.ch] == intc_pkg::CNT_ONE))
            next_r.status[r.ch] = 1'b1;

        next_r.irq = |(next_r.status & next_r.mask);
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            r             <= '0;
            r.waitrequest <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign readdata    = r.readdata;
    assign waitrequest = r.waitrequest;
    assign int_req     = r.int_req;
    assign int_vector  = r.int_vector;
    assign int_level   = r.int_level;
    assign xfer_req    = r.xfer_req;
    assign xfer_src    = r.xfer_src;
    assign xfer_dst    = r.xfer_dst;
    assign xfer_word   = r.xfer_word;
    assign trap_ack    = r.trap_ack;
    assign irq         = r.irq;

endmodule : interrupt_and_event_transfer_ctrl

// ### intc_checker_properties.sv
// Port checker for the controller.
// Assumes one clock and synchronous reset; bound below.
`timescale 1ns/10ps
module intc_checker
(
    input wire logic                        sys_clk,
    input wire logic                        sys_rst,
    input wire logic                        read,
    input wire logic                        write,
    input wire logic                        waitrequest,
    input wire logic [intc_pkg::PRIO_W-1:0] cpu_level,
    input wire logic                        int_ack,
    input wire logic                        xfer_done,
    input wire logic                        trap_valid,
    input wire logic [7:0]                  trap_num,
    input wire logic                        int_req,
    input wire logic [15:0]                 int_vector,
    input wire logic [intc_pkg::PRIO_W-1:0] int_level,
    input wire logic                        xfer_req,
    input wire logic [15:0]                 xfer_src,
    input wire logic [15:0]                 xfer_dst,
    input wire logic                        trap_ack
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence bus_taken;
        (read || write) && waitrequest;
    endsequence
    sequence bus_answer;
        !waitrequest ##1 waitrequest;
    endsequence
    sequence vec_taken;
        int_req && int_ack;
    endsequence
    chk_bus_answer: assert property (bus_taken |=> bus_answer)
        else $error("Bus answer late.");
    chk_vector_held: assert property (int_req && !int_ack |=> int_req && $stable(int_vector))
        else $error("Vector not held.");
    chk_vector_release: assert property (vec_taken |=> !int_req)
        else $error("Vector not released.");
    chk_move_held: assert property (xfer_req && !xfer_done |=> xfer_req && $stable(xfer_src)
        && $stable(xfer_dst))
        else $error("Move not held.");
    chk_move_steal: assert property (xfer_req && xfer_done |=> !xfer_req)
        else $error("Move not released.");
    chk_one_kind: assert property (!(int_req && xfer_req))
        else $error("Two requests at once.");
    chk_trap_entry: assert property (trap_ack |-> int_req
        && int_vector == {6'h00, $past(trap_num), 2'h0})
        else $error("Trap vector wrong.");
    chk_trap_cause: assert property (trap_ack |-> $past(trap_valid) ##1 !trap_ack)
        else $error("Trap accept not caused.");
    chk_level_above: assert property ($rose(int_req) && !trap_ack
        |-> int_level > $past(cpu_level))
        else $error("Vector level too low.");
endmodule : intc_checker

bind interrupt_and_event_transfer_ctrl intc_checker intc_checker_inst (.*);

// ### core_model.sv
// Behavioural core: takes vectors and moves after a set delay.
// Assumes the service link on the same clock.
`timescale 1ns/10ps
module core_model
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  delay,
    input  wire logic        int_req,
    input  wire logic [15:0] int_vector,
    input  wire logic [3:0]  int_level,
    input  wire logic        xfer_req,
    input  wire logic [15:0] xfer_src,
    input  wire logic [15:0] xfer_dst,
    input  wire logic        xfer_word,
    output logic             int_ack,
    output logic             xfer_done,
    output int               n_vec,
    output int               n_xfer,
    output logic [15:0]      last_vec,
    output logic [3:0]       last_lvl,
    output logic [15:0]      last_src,
    output logic [15:0]      last_dst,
    output logic             last_word
);
    logic [3:0] wait_cnt;
    // A slow answer keeps the request standing, which the hold checks need.
    always @(posedge sys_clk)
    begin
        if (sys_rst || int_ack || xfer_done)
        begin
            int_ack   <= 1'b0;
            xfer_done <= 1'b0;
            wait_cnt  <= 4'h0;
            if (sys_rst)
            begin
                n_vec  <= 0;
                n_xfer <= 0;
            end
        end
        else if ((int_req || xfer_req) && wait_cnt >= delay)
        begin
            int_ack   <= int_req;
            xfer_done <= xfer_req;
            n_vec     <= n_vec + int'(int_req);
            n_xfer    <= n_xfer + int'(xfer_req);
            if (int_req)
            begin
                last_vec <= int_vector;
                last_lvl <= int_level;
            end
            if (xfer_req)
            begin
                last_src  <= xfer_src;
                last_dst  <= xfer_dst;
                last_word <= xfer_word;
            end
        end
        else if (int_req || xfer_req)
            wait_cnt <= wait_cnt + 4'h1;
    end
endmodule : core_model

// ### testbench.sv
// Self-checking bench for the controller.
// Assumes the core model and Avalon-MM register access.
`timescale 1ns/10ps
module testbench;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, read = 1'b0, write = 1'b0, trap_valid = 1'b0;
    logic [7:0]  address = 8'h00, src_event = 8'h00, trap_num = 8'h00;
    logic [31:0] writedata = 32'h0000_0000, readdata, rd_val;
    logic [3:0]  byteenable = 4'hF, cpu_level = 4'hF, delay = 4'h0, int_level, last_lvl;
    logic [1:0]  ext_pin = 2'h0;
    logic        waitrequest, int_req, int_ack, xfer_req, xfer_done, xfer_word, trap_ack, irq;
    logic        last_word;
    logic [15:0] int_vector, xfer_src, xfer_dst, last_vec, last_src, last_dst;
    int          n_vec, n_xfer, fail_count = 0, n_checks = 0, cyc = 0, lat, nv = 0;
    interrupt_and_event_transfer_ctrl interrupt_and_event_transfer_ctrl_inst (.*);
    core_model core_model_inst (.*);
    always #20 sys_clk = ~sys_clk;
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic bus(input logic rw, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge sys_clk);
        address    <= a;
        writedata  <= d;
        byteenable <= be;
        write      <= rw;
        read       <= !rw;
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        rd_val = readdata;
        write <= 1'b0;
        read  <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
        bus(1'b1, a, d, be);
    endtask : wr
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
        chk(n, e, rd_val);
    endtask : rc
    task automatic pulse(input logic [7:0] m);
        @(posedge sys_clk);
        src_event <= m;
        @(posedge sys_clk);
        src_event <= 8'h00;
    endtask : pulse
    task automatic wait_core(input int v, input int x);
        for (int k = 0; k < 100 && (n_vec < v || n_xfer < x); k++)
            @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
        chk("vector count", v, n_vec);
        chk("move count", x, n_xfer);
    endtask : wait_core
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    // The ceiling is over fifty times the expected run, so only a hang reaches it.
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            test_done();
        end
    end
    initial
    begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rc("ctrl0 reset", 8'h00, 32'h0000_0000);
        wr(8'h04, 32'h0000_FFFF, 4'h1);
        rc("ctrl1 lane", 8'h04, 32'h0000_007F);
        wr(8'h04, 32'h0000_FFFF);
        rc("ctrl1 full", 8'h04, 32'h0000_377F);
        wr(8'hC0, 32'h0000_FFFF);
        rc("unmapped", 8'hC0, 32'h0000_0000);
        chk("top level held", 0, n_vec);
        wr(8'h04, 32'h0000_0000);
        cpu_level <= 4'h0;
        wr(8'h0C, 32'h0000_0035);
        wait_core(1, 0);
        chk("soft vector", 32'h0000_004C, 32'(last_vec));
        rc("flag cleared", 8'h0C, 32'h0000_0015);
        wr(8'h08, 32'h0000_0013);
        pulse(8'h04);
        for (lat = 0; int_req !== 1'b1 && lat < 20; lat++)
            @(posedge sys_clk);
        chk("latency", 1, 32'(lat <= 12));
        wait_core(2, 0);
        chk("event vector", 32'h0000_0048, 32'(last_vec));
        cpu_level <= 4'h6;
        wr(8'h10, 32'h0000_0014);
        wr(8'h14, 32'h0000_0019);
        pulse(8'h30);
        wait_core(3, 0);
        chk("high first", 32'h0000_0054, 32'(last_vec));
        chk("high level", 32'h0000_0009, 32'(last_lvl));
        repeat (20) @(posedge sys_clk);
        chk("low held", 3, n_vec);
        rc("low pending", 8'h10, 32'h0000_0034);
        cpu_level <= 4'h3;
        wait_core(4, 0);
        chk("low after", 32'h0000_0050, 32'(last_vec));
        nv = 4;
        cpu_level <= 4'h0;
        for (int m = 1; m < 4; m++)
        begin
            wr(8'h00, {18'h0_0000, 2'(m), 12'h011});
            ext_pin <= 2'h3;
            repeat (10) @(posedge sys_clk);
            ext_pin <= 2'h0;
            repeat (10) @(posedge sys_clk);
            nv += (m == 3) ? 2 : 1;
            wait_core(nv, 0);
            chk("pin vector", 32'h0000_0040, 32'(last_vec));
        end
        delay <= 4'h3;
        wr(8'h28, 32'h0000_1000);
        wr(8'h48, 32'h0000_2000);
        wr(8'h68, 32'h0000_0002);
        wr(8'h88, 32'h0000_0002);
        wr(8'h18, 32'h0000_0252);
        pulse(8'h40);
        wait_core(nv, 1);
        chk("move src", 32'h0000_1000, 32'(last_src));
        chk("move dst", 32'h0000_2000, 32'(last_dst));
        chk("move word", 1, 32'(last_word));
        pulse(8'h40);
        nv++;
        wait_core(nv, 2);
        chk("move src step", 32'h0000_1002, 32'(last_src));
        chk("zero vector", 32'h0000_0058, 32'(last_vec));
        rc("count", 8'h68, 32'h0000_0000);
        rc("src ptr", 8'h28, 32'h0000_1004);
        rc("dst ptr", 8'h48, 32'h0000_2000);
        rc("status", 8'hA0, 32'h0000_0004);
        chk("irq masked", 0, 32'(irq));
        wr(8'hA4, 32'h0000_0004);
        repeat (2) @(posedge sys_clk);
        chk("irq on", 1, 32'(irq));
        wr(8'hA0, 32'h0000_0004);
        repeat (2) @(posedge sys_clk);
        chk("irq off", 0, 32'(irq));
        rc("status clear", 8'hA0, 32'h0000_0000);
        wr(8'h3C, 32'h0000_3000);
        wr(8'h5C, 32'h0000_4000);
        wr(8'h7C, 32'h0000_0001);
        wr(8'h9C, 32'h0000_000D);
        wr(8'h1C, 32'h0000_0757);
        pulse(8'h80);
        wait_core(nv, 3);
        chk("byte move", 0, 32'(last_word));
        rc("cont count", 8'h7C, 32'h0000_0001);
        rc("dst step", 8'h5C, 32'h0000_4001);
        @(posedge sys_clk);
        trap_valid <= 1'b1;
        trap_num   <= 8'h2A;
        @(posedge sys_clk);
        trap_valid <= 1'b0;
        nv++;
        wait_core(nv, 3);
        chk("trap vector", 32'h0000_00A8, 32'(last_vec));
        test_done();
    end
endmodule : testbench
